// ===== common/cmp_lut_pkg.sv
// Shared constants and types for the comparator lookup logic
`default_nettype none
package cmp_lut_pkg;
  // Sizes
  localparam int NUM_CMP = 2;
  localparam int NUM_LUT = 2;
  localparam int CTRL_W = 4;
  localparam int LINE_W = 4;
  localparam int SYNC_STAGES = 3;

  // Input source kinds of a comparator multiplexer
  typedef enum logic [1:0] {
    SRC_GLOBAL = 2'b00,
    SRC_MUXLINE = 2'b01,
    SRC_LOCAL = 2'b10,
    SRC_VREF = 2'b11
  } src_e;

  // Speed and power trade-off of a comparator
  typedef enum logic [1:0] {
    MODE_FAST = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_ULP = 2'b10
  } mode_e;

  // Positive input filter choice
  typedef enum logic [1:0] {
    FILT_BYPASS = 2'b00,
    FILT_LP0 = 2'b01,
    FILT_LP1 = 2'b10
  } filt_e;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [LINE_W-1:0] LINE_RST = 4'h0;
  localparam src_e SRC_RST = SRC_GLOBAL;
  localparam mode_e MODE_RST = MODE_SLOW;
  localparam filt_e FILT_RST = FILT_BYPASS;
  localparam logic SEL_RST = 1'b0;

  // Lookup index is formed from the inverted inputs
  function automatic logic lut_eval(input logic [CTRL_W-1:0] ctrl,
                                    input logic a, input logic b);
    lut_eval = ctrl[{~a, ~b}];
  endfunction : lut_eval
endpackage : cmp_lut_pkg
`default_nettype wire

// ===== logic/lut_cell.sv
// Two input, one output lookup cell
`default_nettype none
module lut_cell (
  // Function word
  input wire logic [cmp_lut_pkg::CTRL_W-1:0] ctrl,
  // Operands
  input wire logic in_a,
  input wire logic in_b,
  // Result, combinational
  output logic out
);
  import cmp_lut_pkg::*;

  // Control bit chosen by the inverted operands
  assign out = lut_eval(ctrl, in_a, in_b);
endmodule : lut_cell
`default_nettype wire

// ===== logic/comparator_lookup_logic.sv
// Digital side of the two comparators: sync, lookup units, config
`default_nettype none
// Behaviour
// - Two lookup units, two inputs, one output
// - Either comparator may feed either unit input
// - Software writes 4-bit word per unit
// - Output is word bit at {~A,~B}
// - Lookup outputs go to fabric interface
// - Per-input source select for both comparator inputs
// - Mode select: fast, slow, ultra low power
// - Positive input filter: two filters or bypass
module comparator_lookup_logic (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw comparator decisions, asynchronous
  input wire logic [cmp_lut_pkg::NUM_CMP-1:0] cmp_raw,
  // Lookup unit write port
  input wire logic lut_wr,
  input wire logic lut_wr_unit,
  input wire logic [cmp_lut_pkg::CTRL_W-1:0] lut_wr_ctrl,
  input wire logic lut_wr_src_a,
  input wire logic lut_wr_src_b,
  // Comparator configuration write port
  input wire logic cfg_wr,
  input wire logic cfg_wr_cmp,
  input wire cmp_lut_pkg::src_e cfg_pos_kind,
  input wire logic [cmp_lut_pkg::LINE_W-1:0] cfg_pos_line,
  input wire cmp_lut_pkg::src_e cfg_neg_kind,
  input wire logic [cmp_lut_pkg::LINE_W-1:0] cfg_neg_line,
  input wire logic [1:0] cfg_mode,
  input wire logic [1:0] cfg_filt,
  // Results toward the logic fabric
  output logic [cmp_lut_pkg::NUM_LUT-1:0] lut_out,
  output logic [cmp_lut_pkg::NUM_CMP-1:0] cmp_level,
  // Readback of stored lookup setup
  output logic [cmp_lut_pkg::NUM_LUT-1:0][cmp_lut_pkg::CTRL_W-1:0] lut_ctrl,
  output logic [cmp_lut_pkg::NUM_LUT-1:0] lut_src_a,
  output logic [cmp_lut_pkg::NUM_LUT-1:0] lut_src_b,
  // Settings toward the analog comparators
  output cmp_lut_pkg::src_e [cmp_lut_pkg::NUM_CMP-1:0] pos_kind,
  output logic [cmp_lut_pkg::NUM_CMP-1:0][cmp_lut_pkg::LINE_W-1:0] pos_line,
  output cmp_lut_pkg::src_e [cmp_lut_pkg::NUM_CMP-1:0] neg_kind,
  output logic [cmp_lut_pkg::NUM_CMP-1:0][cmp_lut_pkg::LINE_W-1:0] neg_line,
  output cmp_lut_pkg::mode_e [cmp_lut_pkg::NUM_CMP-1:0] cmp_mode,
  output cmp_lut_pkg::filt_e [cmp_lut_pkg::NUM_CMP-1:0] pos_filt
);
  import cmp_lut_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [NUM_CMP-1:0][SYNC_STAGES-1:0] meta;
    logic [NUM_CMP-1:0] cmp_q;
    logic [NUM_LUT-1:0][CTRL_W-1:0] ctrl;
    logic [NUM_LUT-1:0] src_a;
    logic [NUM_LUT-1:0] src_b;
    logic [NUM_LUT-1:0] lut_q;
    src_e [NUM_CMP-1:0] pos_kind;
    logic [NUM_CMP-1:0][LINE_W-1:0] pos_line;
    src_e [NUM_CMP-1:0] neg_kind;
    logic [NUM_CMP-1:0][LINE_W-1:0] neg_line;
    mode_e [NUM_CMP-1:0] mode;
    filt_e [NUM_CMP-1:0] filt;
  } state_s;

  state_s r;
  state_s r_nxt;
  logic [NUM_LUT-1:0] a_in;
  logic [NUM_LUT-1:0] b_in;
  logic [NUM_LUT-1:0] lut_val;

  // Code 2'b11 is unused for both mode and filter
  function automatic logic mode_ok(input logic [1:0] code);
    mode_ok = (code == MODE_FAST) || (code == MODE_SLOW) ||
              (code == MODE_ULP);
  endfunction : mode_ok

  function automatic logic filt_ok(input logic [1:0] code);
    filt_ok = (code == FILT_BYPASS) || (code == FILT_LP0) ||
              (code == FILT_LP1);
  endfunction : filt_ok

  // Lookup units, each fed by a selectable comparator pair
  for (genvar u = 0; u < NUM_LUT; u++) begin : g_lut
    assign a_in[u] = r.cmp_q[r.src_a[u]];
    assign b_in[u] = r.cmp_q[r.src_b[u]];
    lut_cell u_cell (
      .ctrl(r.ctrl[u]),
      .in_a(a_in[u]),
      .in_b(b_in[u]),
      .out(lut_val[u])
    );
  end

  // Next state
  always_comb begin
    r_nxt = r;
    for (int i = 0; i < NUM_CMP; i++) begin
      // Three stages; a change counts once stages two and three agree
      r_nxt.meta[i] = {r.meta[i][1:0], cmp_raw[i]};
      if (r.meta[i][1] == r.meta[i][2]) begin
        r_nxt.cmp_q[i] = r.meta[i][1];
      end
    end
    // Registered so the fabric sees a glitch-free level
    r_nxt.lut_q = lut_val;
    if (lut_wr) begin
      r_nxt.ctrl[lut_wr_unit] = lut_wr_ctrl;
      r_nxt.src_a[lut_wr_unit] = lut_wr_src_a;
      r_nxt.src_b[lut_wr_unit] = lut_wr_src_b;
    end
    if (cfg_wr) begin
      r_nxt.pos_kind[cfg_wr_cmp] = cfg_pos_kind;
      r_nxt.pos_line[cfg_wr_cmp] = cfg_pos_line;
      r_nxt.neg_kind[cfg_wr_cmp] = cfg_neg_kind;
      r_nxt.neg_line[cfg_wr_cmp] = cfg_neg_line;
      // Unused codes keep the old setting rather than a bad bias
      if (mode_ok(cfg_mode)) begin
        r_nxt.mode[cfg_wr_cmp] = mode_e'(cfg_mode);
      end
      if (filt_ok(cfg_filt)) begin
        r_nxt.filt[cfg_wr_cmp] = filt_e'(cfg_filt);
      end
    end
    if (rst) begin
      r_nxt = '0;
      for (int i = 0; i < NUM_CMP; i++) begin
        r_nxt.pos_kind[i] = SRC_RST;
        r_nxt.pos_line[i] = LINE_RST;
        r_nxt.neg_kind[i] = SRC_RST;
        r_nxt.neg_line[i] = LINE_RST;
        r_nxt.mode[i] = MODE_RST;
        r_nxt.filt[i] = FILT_RST;
      end
      for (int u = 0; u < NUM_LUT; u++) begin
        r_nxt.ctrl[u] = CTRL_RST;
        r_nxt.src_a[u] = SEL_RST;
        r_nxt.src_b[u] = SEL_RST;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    r <= r_nxt;
  end

  // Outputs straight from the state register
  assign lut_out = r.lut_q;
  assign cmp_level = r.cmp_q;
  assign lut_ctrl = r.ctrl;
  assign lut_src_a = r.src_a;
  assign lut_src_b = r.src_b;
  assign pos_kind = r.pos_kind;
  assign pos_line = r.pos_line;
  assign neg_kind = r.neg_kind;
  assign neg_line = r.neg_line;
  assign cmp_mode = r.mode;
  assign pos_filt = r.filt;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Raw bit held steady for four samples
  sequence raw0_steady;
    $stable(cmp_raw[0]) [*4];
  endsequence

  sequence setup0_steady;
    $stable(r.ctrl[0]) && $stable(r.src_a[0]) && $stable(r.src_b[0]);
  endsequence

  sync_settle_a:
    assert property (raw0_steady |=> r.cmp_q[0] == $past(cmp_raw[0], 2))
    else $error("settled comparator level does not follow steady input");

  sync_noglitch_a:
    assert property ($changed(r.cmp_q[1]) |->
                     $past(r.meta[1][1]) == $past(r.meta[1][2]))
    else $error("comparator level changed without stage agreement");

  lut_index_a:
    assert property (##1 lut_out[1] ==
                     $past(r.ctrl[1][{~a_in[1], ~b_in[1]}]))
    else $error("lookup output not the indexed control bit");

  lut_const_a:
    assert property (r.ctrl[0] == 4'h0 ##1 r.ctrl[0] == 4'h0
                     |-> !lut_out[0])
    else $error("constant low code drives a high output");

  lut_xor_a:
    assert property (r.ctrl[1] == 4'h6 |=>
                     lut_out[1] == ($past(a_in[1]) ^ $past(b_in[1])))
    else $error("exclusive or code gives wrong output");

  deliver_a:
    assert property (setup0_steady ##0 r.ctrl[0] == 4'h3 |=>
                     lut_out[0] == $past(r.cmp_q[r.src_a[0]]))
    else $error("pass-through code does not deliver selected level");

  two_units_a:
    assert property (r.ctrl[0] == r.ctrl[1] && r.src_a[0] == r.src_a[1]
                     && r.src_b[0] == r.src_b[1] |=> lut_out[0] == lut_out[1])
    else $error("identical lookup setups give different outputs");

  route_sel_a:
    assert property (lut_ctrl[1] == 4'h5 |=>
                     lut_out[1] == $past(cmp_level[lut_src_b[1]]))
    else $error("lookup input not taken from selected comparator");

  ctrl_store_a:
    assert property (lut_wr && !lut_wr_unit |=>
                     r.ctrl[0] == $past(lut_wr_ctrl) ##1
                     (lut_out[0] == $past(lut_eval(r.ctrl[0], a_in[0],
                                                  b_in[0]))))
    else $error("written control word not stored or not used");

  ctrl_hold_a:
    assert property (!lut_wr |=> $stable(r.ctrl))
    else $error("control word changed without a write");

  mux_sel_a:
    assert property (cfg_wr && cfg_wr_cmp |=>
                     pos_kind[1] == $past(cfg_pos_kind) &&
                     neg_line[1] == $past(cfg_neg_line))
    else $error("input source select not stored");

  mode_set_a:
    assert property (cfg_wr && mode_ok(cfg_mode) |=>
                     cmp_mode[$past(cfg_wr_cmp)] == $past(cfg_mode))
    else $error("legal mode write not applied");

  mode_legal_a:
    assert property (mode_ok(cmp_mode[0]) && mode_ok(cmp_mode[1]))
    else $error("comparator mode holds the unused code");

  filt_set_a:
    assert property (cfg_wr && !filt_ok(cfg_filt) |=> $stable(pos_filt))
    else $error("unused filter code altered the filter setting");
endmodule : comparator_lookup_logic
`default_nettype wire

// ===== verif/fabric_sink.sv
// Fabric side model that consumes the lookup results
`default_nettype none
module fabric_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Lookup results from the block
  input wire logic [1:0] lut_in,
  // Resynchronised copy
  output logic [1:0] lut_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] s1_r;
  // Two stages, since the bits may be unrelated to our clock
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= 2'h0;
      lut_sync <= 2'h0;
    end else begin
      s1_r <= lut_in;
      lut_sync <= s1_r;
    end
  end
endmodule : fabric_sink
`default_nettype wire

// ===== verif/comparator_lookup_logic_test.sv
// Self-checking bench for the comparator lookup logic
`default_nettype none
module comparator_lookup_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_lut_pkg::*;
  logic clk, rst, lut_wr, lut_wr_unit, lut_wr_src_a, lut_wr_src_b;
  logic cfg_wr, cfg_wr_cmp;
  logic [1:0] cmp_raw, cfg_mode, cfg_filt, lut_out, cmp_level, lut_sync;
  logic [1:0] lut_src_a, lut_src_b;
  logic [3:0] lut_wr_ctrl, cfg_pos_line, cfg_neg_line;
  src_e cfg_pos_kind, cfg_neg_kind;
  logic [1:0][3:0] lut_ctrl, pos_line, neg_line;
  src_e [1:0] pos_kind, neg_kind;
  mode_e [1:0] cmp_mode;
  filt_e [1:0] pos_filt;
  int n_fail, check_count;
  comparator_lookup_logic u_comparator_lookup_logic (.clk, .rst,
    .cmp_raw, .lut_wr, .lut_wr_unit, .lut_wr_ctrl, .lut_wr_src_a,
    .lut_wr_src_b, .cfg_wr, .cfg_wr_cmp, .cfg_pos_kind, .cfg_pos_line,
    .cfg_neg_kind, .cfg_neg_line, .cfg_mode, .cfg_filt, .lut_out,
    .cmp_level, .lut_ctrl, .lut_src_a, .lut_src_b, .pos_kind, .pos_line,
    .neg_kind, .neg_line, .cmp_mode, .pos_filt);
  fabric_sink u_fabric_sink (.clk, .rst, .lut_in(lut_out), .lut_sync);
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Leaves us 1 ns past an edge, where all drives happen
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_lut(logic u, logic [3:0] c, logic sa, logic sb);
    lut_wr = 1'b1;
    lut_wr_unit = u;
    lut_wr_ctrl = c;
    lut_wr_src_a = sa;
    lut_wr_src_b = sb;
    tick(1);
    lut_wr = 1'b0;
  endtask : wr_lut
  task automatic t_reset();
    chk("mode0", 8'(MODE_SLOW), 8'(cmp_mode[0]));
    chk("filt0", 8'(FILT_BYPASS), 8'(pos_filt[0]));
    chk("kind0", 8'(SRC_GLOBAL), 8'(pos_kind[0]));
    chk("ctrl", 8'h0, 8'(lut_ctrl));
    $display("t_reset done");
  endtask : t_reset
  // Every code against every input pair, seen at the fabric too
  task automatic t_lut();
    logic [3:0] c;
    logic [1:0] v;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr_lut(1'b0, c, 1'b0, 1'b1);
      chk("ctrl0", 8'(c), 8'(lut_ctrl[0]));
      tick(1);
      // Same setup on the second unit, so both must agree
      wr_lut(1'b1, c, 1'b0, 1'b1);
      chk("ctrl1", 8'(c), 8'(lut_ctrl[1]));
      for (int j = 0; j < 4; j++) begin
        v = 2'(j);
        cmp_raw = v;
        tick(7);
        chk("level", 8'(v), 8'(cmp_level));
        chk("out0", 8'(c[{~v[0], ~v[1]}]), 8'(lut_out[0]));
        chk("sink", 8'(c[{~v[0], ~v[1]}]), 8'(lut_sync[0]));
        chk("out1", 8'(c[{~v[0], ~v[1]}]), 8'(lut_out[1]));
        chk("sink1", 8'(c[{~v[0], ~v[1]}]), 8'(lut_sync[1]));
      end
    end
    $display("t_lut done");
  endtask : t_lut
  task automatic t_route();
    wr_lut(1'b1, 4'h3, 1'b1, 1'b0);
    cmp_raw = 2'h2;
    tick(6);
    chk("srca1", 8'h2, 8'(lut_src_a));
    chk("srcb", 8'h1, 8'(lut_src_b));
    chk("out1", 8'h1, 8'(lut_out[1]));
    cmp_raw = 2'h1;
    tick(6);
    chk("out1", 8'h0, 8'(lut_out[1]));
    // Both inputs on one comparator: A and not B is never true
    wr_lut(1'b1, 4'h2, 1'b1, 1'b1);
    cmp_raw = 2'h2;
    tick(6);
    chk("out1", 8'h0, 8'(lut_out[1]));
    $display("t_route done");
  endtask : t_route
  // Code 3 of mode and filter must keep the old setting
  task automatic t_cfg();
    for (int m = 0; m < 4; m++) begin
      cfg_wr = 1'b1;
      cfg_wr_cmp = 1'b1;
      cfg_pos_kind = src_e'(m);
      cfg_neg_kind = src_e'(3 - m);
      cfg_pos_line = 4'(m + 9);
      cfg_neg_line = 4'(m);
      cfg_mode = 2'(m);
      cfg_filt = 2'(m);
      tick(1);
      cfg_wr = 1'b0;
      chk("pkind", 8'(m), 8'(pos_kind[1]));
      chk("nkind", 8'(3 - m), 8'(neg_kind[1]));
      chk("pline", 8'(m + 9), 8'(pos_line[1]));
      chk("nline", 8'(m), 8'(neg_line[1]));
      chk("mode1", 8'(m == 3 ? 2 : m), 8'(cmp_mode[1]));
      chk("filt1", 8'(m == 3 ? 2 : m), 8'(pos_filt[1]));
      chk("mode0", 8'(MODE_SLOW), 8'(cmp_mode[0]));
      // Let an edge pass before the strobe rises again
      tick(1);
    end
    $display("t_cfg done");
  endtask : t_cfg
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // Tests need about 550 cycles
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
  initial begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    cmp_raw = 2'h0;
    lut_wr = 1'b0;
    lut_wr_unit = 1'b0;
    lut_wr_ctrl = 4'h0;
    lut_wr_src_a = 1'b0;
    lut_wr_src_b = 1'b0;
    cfg_wr = 1'b0;
    cfg_wr_cmp = 1'b0;
    cfg_pos_kind = SRC_GLOBAL;
    cfg_neg_kind = SRC_GLOBAL;
    cfg_pos_line = 4'h0;
    cfg_neg_line = 4'h0;
    cfg_mode = 2'h0;
    cfg_filt = 2'h0;
    tick(20);
    rst = 1'b0;
    t_reset();
    t_lut();
    t_route();
    t_cfg();
    close_out();
  end
endmodule : comparator_lookup_logic_test
`default_nettype wire
